/* verilog/pressure_measure_sequencer.sv */
// Measurement sequencer of a barometric sensor core with AXI4-Lite registers.
// Assumes a converter front end on the same clock that answers conv_start
// with one conv_done pulse carrying a 21-bit raw sample.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "pressure_consts.svh"

// Function
// RQ1 - Mode code 00 sleep, 01 or 10 forced, 11 normal.
// RQ2 - After reset sleep; no conversions, registers stay accessible.
// RQ3 - Reset returns logic state and all registers to defaults.
// RQ4 - Reset-detected flag set on reset completion, cleared when host reads it.
// RQ5 - Forced mode runs one measurement, updates results, returns to sleep.
// RQ6 - Host must rewrite forced mode for each further single result.
// RQ7 - Normal mode cycles measure and standby; period is prescaler over 200 Hz.
// RQ8 - Normal mode refreshes result registers every period without host writes.
// RQ9 - Mode change during a measurement waits until that period ends.
// RQ10 - Writes during a pending change, and illegal transitions, are ignored; code drops only the mode request, enable bits still update.
// RQ11 - Period runs enabled conversions, then the optional smoothing filter.
// RQ12 - Control bit 0 enables the pressure conversion.
// RQ13 - Control bit 1 enables the temperature conversion.
// RQ14 - Pressure oversampling code bits 2:0, 1 to 32 samples, 16 to 21 bits.
// RQ15 - Temperature oversampling bits 5:3, 1 to 32 samples, up to 21 bits.
// RQ16 - Host should pair low temperature oversampling with pressure setting.
// RQ17 - Filter output is (old times coefficient plus new) over coefficient plus one.
// RQ18 - Coefficient 0 disables filtering, maximum 127.
// RQ19 - Coefficient write clears filter; next result passes and seeds it.
// RQ20 - Filter cleared on enable falling and on sleep to normal.
// RQ21 - Re-enabled channel's first result bypasses filter and seeds history.
// RQ22 - Skipped channel keeps old result; temperature converts before pressure.
module pressure_measure_sequencer #(
  parameter int BASE_PERIOD_CYCLES = `BASE_PERIOD_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`ADDR_WIDTH-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`ADDR_WIDTH-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output pressure_pkg::conv_req_t conv_req,
  input wire logic conv_done,
  input wire logic [`DATA_WIDTH-1:0] conv_data
);

  // A period longer than the counter or a zero base cannot be served
  if (BASE_PERIOD_CYCLES < 1 || BASE_PERIOD_CYCLES > 32'h00FF_FFFF)
  begin : bad_base_period
    $error("BASE_PERIOD_CYCLES out of range");
  end

  pressure_pkg::state_t s;
  pressure_pkg::state_t next_s;

  // Keep only the resolution bits the oversampling code earns
  function automatic logic [`DATA_WIDTH-1:0] trim(
    input logic [`DATA_WIDTH-1:0] raw,
    input logic [2:0] code
  );
    logic [2:0] c;
    logic [`DATA_WIDTH-1:0] mask;
    c = (code > `OSR_MAX_CODE) ? `OSR_MAX_CODE : code;
    mask = {`DATA_WIDTH{1'b1}} << (3'(`OSR_MAX_CODE) - c); // RQ14 RQ15
    trim = raw & mask;
  endfunction : trim

  // Recursive smoothing step; divide kept combinational for a short path count
  function automatic logic [`DATA_WIDTH-1:0] smooth(
    input logic [`DATA_WIDTH-1:0] old,
    input logic [`DATA_WIDTH-1:0] fresh,
    input logic [`COEFF_WIDTH-1:0] coeff
  );
    logic [29:0] num;
    logic [29:0] den;
    num = 30'(old) * 30'(coeff) + 30'(fresh); // RQ17
    den = 30'(coeff) + 30'h0000_0001;
    smooth = `DATA_WIDTH'(num / den);
  endfunction : smooth

  // Mode code decode: both middle codes mean a single shot
  function automatic pressure_pkg::power_mode_t decode_mode(input logic [1:0] code);
    case (code)
      2'b00: decode_mode = pressure_pkg::MODE_SLEEP; // RQ1
      2'b11: decode_mode = pressure_pkg::MODE_NORMAL; // RQ1
      default: decode_mode = pressure_pkg::MODE_FORCED; // RQ1
    endcase
  endfunction : decode_mode

  // Legal moves go through sleep; forced and normal never switch directly
  function automatic logic mode_legal(
    input pressure_pkg::power_mode_t cur,
    input pressure_pkg::power_mode_t req
  );
    mode_legal = (cur != req) &&
                 (cur == pressure_pkg::MODE_SLEEP || req == pressure_pkg::MODE_SLEEP);
  endfunction : mode_legal

  logic [`PERIOD_WIDTH-1:0] period_limit;
  logic [`ODR_WIDTH-1:0] odr_eff;
  logic measuring;
  logic [31:0] read_word;
  logic read_ok;

  // Sampling period: base period times two to the rate code, rate code capped at ODR_MAX
  assign odr_eff = (s.core.odr_sel > `ODR_MAX) ? `ODR_MAX : s.core.odr_sel;
  assign period_limit = `PERIOD_WIDTH'(BASE_PERIOD_CYCLES) << odr_eff; // RQ7
  assign measuring = (s.core.seq != pressure_pkg::SEQ_IDLE) &&
                     (s.core.seq != pressure_pkg::SEQ_STANDBY);

  // Read decode; unmapped addresses answer with an error
  always_comb
  begin
    read_word = 32'h0000_0000;
    read_ok = 1'b1;
    case (araddr)
      `ADDR_MEASURE_CONTROL:
      begin
        read_word[`PRESS_EN_BIT] = s.core.press_en;
        read_word[`TEMP_EN_BIT] = s.core.temp_en;
        read_word[`MODE_MSB:`MODE_LSB] = s.core.mode;
      end
      `ADDR_OVERSAMPLING: read_word[5:0] = s.core.osr;
      `ADDR_FILTER_CONFIG: read_word[`COEFF_WIDTH-1:0] = s.core.coeff;
      `ADDR_RATE_SELECT: read_word[`ODR_WIDTH-1:0] = s.core.odr_sel;
      `ADDR_STATUS:
      begin
        read_word[`STAT_RESET_BIT] = s.core.reset_flag;
        read_word[`STAT_BUSY_BIT] = measuring;
        read_word[`STAT_PENDING_BIT] = s.core.pending;
      end
      // Low byte carries the extra oversampling bits
      `ADDR_TEMP_RESULT: read_word[23:0] = {s.core.temp_res, {`LOW_PAD{1'b0}}}; // RQ15
      `ADDR_PRESS_RESULT: read_word[23:0] = {s.core.press_res, {`LOW_PAD{1'b0}}};
      `ADDR_SOFT_RESET: read_word = 32'h0000_0000;
      default: read_ok = 1'b0;
    endcase
  end

  // All next-state logic
  always_comb
  begin
    logic [7:0] wd;
    logic soft_reset;
    logic apply_normal;
    pressure_pkg::power_mode_t req;
    wd = s.axi.wdata;
    soft_reset = 1'b0;
    apply_normal = 1'b0;
    req = pressure_pkg::MODE_SLEEP;
    next_s = s;
    next_s.core.conv.start = 1'b0;

    // Period counter runs from each measurement start in normal mode
    if (s.core.seq != pressure_pkg::SEQ_IDLE)
    begin
      next_s.core.period_cnt = s.core.period_cnt + `PERIOD_WIDTH'(1);
    end

    // Measurement sequence
    case (s.core.seq)
      pressure_pkg::SEQ_IDLE:
      begin
        // Sleep performs no conversions
        if (s.core.mode != pressure_pkg::MODE_SLEEP) // RQ2
        begin
          next_s.core.seq = pressure_pkg::SEQ_TEMP_START;
          next_s.core.period_cnt = '0;
        end
      end
      pressure_pkg::SEQ_TEMP_START:
      begin
        // Temperature first; a disabled channel is skipped and keeps its result
        if (s.core.temp_en) // RQ13 RQ22
        begin
          next_s.core.conv.start = 1'b1;
          next_s.core.conv.channel_press = 1'b0;
          next_s.core.conv.osr = s.core.osr[`OSR_T_MSB:`OSR_T_LSB];
          next_s.core.seq = pressure_pkg::SEQ_TEMP_WAIT;
        end
        else
        begin
          next_s.core.seq = pressure_pkg::SEQ_PRESS_START;
        end
      end
      pressure_pkg::SEQ_TEMP_WAIT:
      begin
        if (conv_done)
        begin
          next_s.core.temp_raw = trim(conv_data, s.core.osr[`OSR_T_MSB:`OSR_T_LSB]); // RQ15
          next_s.core.temp_new = 1'b1;
          next_s.core.seq = pressure_pkg::SEQ_PRESS_START;
        end
      end
      pressure_pkg::SEQ_PRESS_START:
      begin
        if (s.core.press_en) // RQ12 RQ22
        begin
          next_s.core.conv.start = 1'b1;
          next_s.core.conv.channel_press = 1'b1;
          next_s.core.conv.osr = s.core.osr[`OSR_P_MSB:`OSR_P_LSB];
          next_s.core.seq = pressure_pkg::SEQ_PRESS_WAIT;
        end
        else
        begin
          next_s.core.seq = pressure_pkg::SEQ_FILTER;
        end
      end
      pressure_pkg::SEQ_PRESS_WAIT:
      begin
        if (conv_done)
        begin
          next_s.core.press_raw = trim(conv_data, s.core.osr[`OSR_P_MSB:`OSR_P_LSB]); // RQ14
          next_s.core.press_new = 1'b1;
          next_s.core.seq = pressure_pkg::SEQ_FILTER;
        end
      end
      pressure_pkg::SEQ_FILTER:
      begin
        // Unseeded or disabled filter passes the sample and seeds history
        if (s.core.temp_new) // RQ11
        begin
          next_s.core.temp_res = (s.core.coeff == '0 || !s.core.temp_seeded) ?
              s.core.temp_raw : smooth(s.core.temp_res, s.core.temp_raw, s.core.coeff); // RQ18 RQ21
          next_s.core.temp_seeded = 1'b1;
          next_s.core.temp_new = 1'b0;
        end
        if (s.core.press_new) // RQ11
        begin
          next_s.core.press_res = (s.core.coeff == '0 || !s.core.press_seeded) ?
              s.core.press_raw : smooth(s.core.press_res, s.core.press_raw, s.core.coeff); // RQ18 RQ21
          next_s.core.press_seeded = 1'b1;
          next_s.core.press_new = 1'b0;
        end
        // Period end: a held mode change takes effect now
        if (s.core.pending) // RQ9
        begin
          next_s.core.mode = s.core.pending_mode;
          next_s.core.pending = 1'b0;
          next_s.core.seq = (s.core.pending_mode == pressure_pkg::MODE_NORMAL) ?
              pressure_pkg::SEQ_STANDBY : pressure_pkg::SEQ_IDLE;
        end
        else if (s.core.mode == pressure_pkg::MODE_FORCED)
        begin
          next_s.core.mode = pressure_pkg::MODE_SLEEP; // RQ5
          next_s.core.seq = pressure_pkg::SEQ_IDLE;
        end
        else
        begin
          next_s.core.seq = pressure_pkg::SEQ_STANDBY; // RQ7
        end
      end
      pressure_pkg::SEQ_STANDBY:
      begin
        // Next period starts on schedule; results keep refreshing
        if (s.core.period_cnt >= period_limit - `PERIOD_WIDTH'(1)) // RQ7 RQ8
        begin
          next_s.core.seq = pressure_pkg::SEQ_TEMP_START;
          next_s.core.period_cnt = '0;
        end
      end
      default: next_s.core.seq = pressure_pkg::SEQ_IDLE;
    endcase

    // Write channel capture; address and data may come in either order
    if (s.axi.awready && awvalid)
    begin
      next_s.axi.aw_held = 1'b1;
      next_s.axi.waddr = awaddr;
    end
    if (s.axi.wready && wvalid)
    begin
      next_s.axi.w_held = 1'b1;
      next_s.axi.wdata = wdata[7:0];
      next_s.axi.wlane0 = wstrb[0];
    end
    if (s.axi.bvalid && bready)
    begin
      next_s.axi.bvalid = 1'b0;
    end

    // Register write once both halves are held
    if (s.axi.aw_held && s.axi.w_held && !s.axi.bvalid)
    begin
      next_s.axi.aw_held = 1'b0;
      next_s.axi.w_held = 1'b0;
      next_s.axi.bvalid = 1'b1;
      next_s.axi.bresp = `RESP_OKAY;
      case (s.axi.waddr)
        `ADDR_MEASURE_CONTROL:
        begin
          if (s.axi.wlane0)
          begin
            next_s.core.press_en = wd[`PRESS_EN_BIT];
            next_s.core.temp_en = wd[`TEMP_EN_BIT];
            // Any enable falling clears both histories
            if ((s.core.press_en && !wd[`PRESS_EN_BIT]) ||
                (s.core.temp_en && !wd[`TEMP_EN_BIT])) // RQ20
            begin
              next_s.core.press_seeded = 1'b0;
              next_s.core.temp_seeded = 1'b0;
            end
            // A channel switched on starts a fresh history
            if (!s.core.press_en && wd[`PRESS_EN_BIT])
            begin
              next_s.core.press_seeded = 1'b0; // RQ21
            end
            if (!s.core.temp_en && wd[`TEMP_EN_BIT])
            begin
              next_s.core.temp_seeded = 1'b0; // RQ21
            end
            req = decode_mode(wd[`MODE_MSB:`MODE_LSB]); // RQ1
            // Held or illegal requests are dropped without an error answer
            if (!s.core.pending && mode_legal(s.core.mode, req)) // RQ10
            begin
              if (measuring) // RQ9
              begin
                next_s.core.pending = 1'b1;
                next_s.core.pending_mode = req;
              end
              else
              begin
                next_s.core.mode = req;
                apply_normal = (req == pressure_pkg::MODE_NORMAL);
                if (req == pressure_pkg::MODE_SLEEP)
                begin
                  next_s.core.seq = pressure_pkg::SEQ_IDLE;
                end
              end
            end
          end
        end
        `ADDR_OVERSAMPLING:
        begin
          if (s.axi.wlane0)
          begin
            next_s.core.osr = wd[5:0];
          end
        end
        `ADDR_FILTER_CONFIG:
        begin
          // Every coefficient write restarts both histories
          if (s.axi.wlane0) // RQ19
          begin
            next_s.core.coeff = wd[`COEFF_WIDTH-1:0]; // RQ18
            next_s.core.press_seeded = 1'b0; // RQ19
            next_s.core.temp_seeded = 1'b0; // RQ19
          end
        end
        `ADDR_RATE_SELECT:
        begin
          if (s.axi.wlane0)
          begin
            next_s.core.odr_sel = wd[`ODR_WIDTH-1:0];
          end
        end
        `ADDR_SOFT_RESET:
        begin
          soft_reset = s.axi.wlane0 && wd[`SOFT_RESET_BIT];
        end
        `ADDR_STATUS, `ADDR_TEMP_RESULT, `ADDR_PRESS_RESULT:
        begin
          // Read-only; the write is accepted and has no effect
        end
        default: next_s.axi.bresp = `RESP_SLVERR;
      endcase
    end

    // Sleep to normal restarts the filter from the first sample
    if (apply_normal) // RQ20
    begin
      next_s.core.press_seeded = 1'b0;
      next_s.core.temp_seeded = 1'b0;
    end

    // Read channel; the status read clears the reset-detected flag
    if (s.axi.rvalid && rready)
    begin
      next_s.axi.rvalid = 1'b0;
    end
    if (s.axi.arready && arvalid)
    begin
      next_s.axi.rvalid = 1'b1;
      next_s.axi.rdata = read_word;
      next_s.axi.rresp = read_ok ? `RESP_OKAY : `RESP_SLVERR;
      if (araddr == `ADDR_STATUS)
      begin
        next_s.core.reset_flag = 1'b0; // RQ4
      end
    end

    // Soft reset returns the core to defaults, flag set; it wins over a read clear
    if (soft_reset) // RQ3 RQ4
    begin
      next_s.core = '0;
      next_s.core.reset_flag = 1'b1;
    end

    // Readies drop while a transfer or its answer is outstanding
    next_s.axi.awready = !next_s.axi.aw_held && !next_s.axi.bvalid;
    next_s.axi.wready = !next_s.axi.w_held && !next_s.axi.bvalid;
    next_s.axi.arready = !next_s.axi.rvalid;
  end

  // State register; reset puts the core in sleep with the flag raised
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0; // RQ2 RQ3
      s.core.reset_flag <= 1'b1; // RQ4
      s.axi.awready <= 1'b1;
      s.axi.wready <= 1'b1;
      s.axi.arready <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign awready = s.axi.awready;
  assign wready = s.axi.wready;
  assign bvalid = s.axi.bvalid;
  assign bresp = s.axi.bresp;
  assign arready = s.axi.arready;
  assign rvalid = s.axi.rvalid;
  assign rdata = s.axi.rdata;
  assign rresp = s.axi.rresp;
  assign conv_req = s.core.conv;

endmodule : pressure_measure_sequencer

/* verilog/pressure_consts.svh */
// Register map, field positions, widths, limits and timing for the sequencer.
// Assumes a 25 MHz core clock and a 32-bit AXI4-Lite register bus.
`ifndef PRESSURE_CONSTS_SVH
`define PRESSURE_CONSTS_SVH

// Register byte addresses
`define ADDR_WIDTH 8
`define ADDR_MEASURE_CONTROL 8'h00
`define ADDR_OVERSAMPLING 8'h04
`define ADDR_FILTER_CONFIG 8'h08
`define ADDR_RATE_SELECT 8'h0C
`define ADDR_STATUS 8'h10
`define ADDR_TEMP_RESULT 8'h14
`define ADDR_PRESS_RESULT 8'h18
`define ADDR_SOFT_RESET 8'h1C

// Measure control fields
`define PRESS_EN_BIT 0
`define TEMP_EN_BIT 1
`define MODE_LSB 4
`define MODE_MSB 5

// Oversampling fields
`define OSR_P_LSB 0
`define OSR_P_MSB 2
`define OSR_T_LSB 3
`define OSR_T_MSB 5
`define OSR_MAX_CODE 3'h5

// Status fields
`define STAT_RESET_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_PENDING_BIT 2

// Widths and limits
`define DATA_WIDTH 21
`define LOW_PAD 3
`define COEFF_WIDTH 7
`define ODR_WIDTH 5
`define ODR_MAX 5'h11
`define PERIOD_WIDTH 40
`define SOFT_RESET_BIT 0

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing: base sampling rate and clock
`define CLK_HZ 25000000
`define BASE_RATE_HZ 200
`define BASE_PERIOD_CYCLES (`CLK_HZ / `BASE_RATE_HZ)

`endif

/* verilog/pressure_pkg.sv */
// Types shared by the pressure measurement sequencer.
// Assumes pressure_consts.svh sits on the include path.
`include "pressure_consts.svh"

package pressure_pkg;

  typedef enum logic [1:0] {
    MODE_SLEEP = 2'b00,
    MODE_FORCED = 2'b01,
    MODE_NORMAL = 2'b11
  } power_mode_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_TEMP_START = 3'b001,
    SEQ_TEMP_WAIT = 3'b010,
    SEQ_PRESS_START = 3'b011,
    SEQ_PRESS_WAIT = 3'b100,
    SEQ_FILTER = 3'b101,
    SEQ_STANDBY = 3'b110
  } seq_state_t;

  // Conversion request toward the converter front end
  typedef struct packed {
    logic start;
    logic channel_press;
    logic [2:0] osr;
  } conv_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_held;
    logic w_held;
    logic [`ADDR_WIDTH-1:0] waddr;
    logic [7:0] wdata;
    logic wlane0;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } axi_state_t;

  typedef struct packed {
    logic press_en;
    logic temp_en;
    power_mode_t mode;
    power_mode_t pending_mode;
    logic pending;
    logic [5:0] osr;
    logic [`COEFF_WIDTH-1:0] coeff;
    logic [`ODR_WIDTH-1:0] odr_sel;
    logic reset_flag;
    seq_state_t seq;
    logic [`PERIOD_WIDTH-1:0] period_cnt;
    logic [`DATA_WIDTH-1:0] temp_raw;
    logic [`DATA_WIDTH-1:0] press_raw;
    logic [`DATA_WIDTH-1:0] temp_res;
    logic [`DATA_WIDTH-1:0] press_res;
    logic temp_new;
    logic press_new;
    logic temp_seeded;
    logic press_seeded;
    conv_req_t conv;
  } core_state_t;

  typedef struct packed {
    axi_state_t axi;
    core_state_t core;
  } state_t;

endpackage : pressure_pkg

/* tb/seq_checker_properties.sv */
// Port-level checks of the measurement sequencer.
// Assumes binding into pressure_measure_sequencer, one clock.
`timescale 1ns/10ps
module seq_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire pressure_pkg::conv_req_t conv_req
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Handshake steps used by the bus properties
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
    awready && wready && arready && !bvalid && !rvalid && !conv_req.start)
    else $error("bus not idle after reset");
  a_sleep_quiet: assert property ($rose(aresetn) |-> !conv_req.start [*4])
    else $error("conversion started in sleep");
  a_write_answer: assert property (wr_take |-> ##2 bvalid)
    else $error("write answer late");
  a_read_answer: assert property (rd_take |=> rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  a_arready_free: assert property (arready == !rvalid)
    else $error("read ready wrong");
  a_start_pulse: assert property (conv_req.start |=> !conv_req.start)
    else $error("start longer than one cycle");
  a_req_steady: assert property (!conv_req.start |->
    $stable({conv_req.channel_press, conv_req.osr}))
    else $error("request fields moved");
endmodule : seq_checker

bind pressure_measure_sequencer seq_checker seq_checker_i (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .conv_req(conv_req));

/* tb/conv_model.sv */
// Behavioural converter front end on the sequencer's clock.
// Assumes the bench supplies the sample value of each channel.
`timescale 1ns/10ps
`include "pressure_consts.svh"
module conv_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pressure_pkg::conv_req_t conv_req,
  input wire logic [`DATA_WIDTH-1:0] t_val,
  input wire logic [`DATA_WIDTH-1:0] p_val,
  output logic conv_done,
  output logic [`DATA_WIDTH-1:0] conv_data
);
  logic [1:0] wait_cnt;
  logic busy;
  logic ch;
  // Fixed answer delay; data toggles outside done so stale values show
  always_ff @(posedge aclk)
  begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (!aresetn)
    begin
      busy <= 1'b0;
      wait_cnt <= 2'd0;
      conv_data <= '0;
    end
    else if (conv_req.start)
    begin
      busy <= 1'b1;
      ch <= conv_req.channel_press;
      wait_cnt <= 2'd2;
    end
    else if (busy && wait_cnt != 2'd0)
      wait_cnt <= wait_cnt - 2'd1;
    else if (busy)
    begin
      busy <= 1'b0;
      conv_done <= 1'b1;
      conv_data <= ch ? p_val : t_val;
    end
  end
endmodule : conv_model

/* tb/tb.sv */
// Self-checking bench: AXI4-Lite host tasks plus a converter model.
// Assumes BASE_PERIOD_CYCLES shrunk to 8 so normal periods stay short.
`timescale 1ns/10ps
`include "pressure_consts.svh"
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, conv_done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [`DATA_WIDTH-1:0] conv_data, t_val = 21'h15_5555, p_val = 21'h0a_aaab;
  pressure_pkg::conv_req_t conv_req;
  int fail_count = 0, tests_run = 0, cycles = 0, starts = 0, last_t = 0, gap = 0;
  pressure_measure_sequencer #(.BASE_PERIOD_CYCLES(8)) pressure_measure_sequencer_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .conv_req(conv_req), .conv_done(conv_done), .conv_data(conv_data));
  conv_model conv_model_i (.aclk(aclk), .aresetn(aresetn), .conv_req(conv_req),
    .t_val(t_val), .p_val(p_val), .conv_done(conv_done), .conv_data(conv_data));
  initial forever #20 aclk = ~aclk;
  // Count starts and temperature start spacing; cut a hang short
  always @(posedge aclk)
  begin
    cycles++;
    if (conv_req.start === 1'b1)
      starts++;
    if (conv_req.start === 1'b1 && conv_req.channel_press === 1'b0)
    begin
      gap = cycles - last_t;
      last_t = cycles;
    end
    if (cycles == 40000)
    begin
      fail_count++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Both channels offered together, both released once both readies are seen
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk);
    while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    rready <= 1'b0;
  endtask : rd
  function automatic logic [31:0] fx(input logic [20:0] v, input logic [2:0] c);
    return {8'h00, v & (21'h1f_ffff << (3'd5 - c)), 3'b000};
  endfunction : fx
  // One single-shot measurement, then wait for the return to sleep
  task automatic forced(input logic [31:0] ctrl, input int n);
    int s = starts;
    wr(`ADDR_MEASURE_CONTROL, ctrl);
    for (int i = 0; i < 100; i++)
    begin
      rd(`ADDR_MEASURE_CONTROL);
      if (d[5:4] === 2'b00) break;
    end
    chk(32'(d[5:4]), 32'h0000_0000, "no return to sleep");
    chk(32'(starts - s), 32'(n), "conversion count");
  endtask : forced
  task automatic wait_starts(input int k);
    int s = starts;
    for (int i = 0; i < 800 && starts < s + k; i++) @(posedge aclk);
  endtask : wait_starts
  task automatic t_reset;
    rd(`ADDR_STATUS);
    chk(32'(d[0]), 32'h0000_0001, "flag after reset");
    rd(`ADDR_STATUS);
    chk(32'(d[0]), 32'h0000_0000, "flag not cleared");
    rd(`ADDR_MEASURE_CONTROL);
    chk(d, 32'h0000_0000, "control default");
    wr(`ADDR_OVERSAMPLING, 32'h0000_000d);
    wr(`ADDR_SOFT_RESET, 32'h0000_0001);
    rd(`ADDR_OVERSAMPLING);
    chk(d, 32'h0000_0000, "soft reset default");
    rd(`ADDR_STATUS);
    chk(32'(d[0]), 32'h0000_0001, "flag after soft reset");
    rd(8'h20);
    chk(32'(rresp), 32'(`RESP_SLVERR), "unmapped read");
    wr(8'h20, 32'h0000_0000);
    chk(32'(bresp), 32'(`RESP_SLVERR), "unmapped write");
    $display("reset test done");
  endtask : t_reset
  task automatic t_osr;
    for (int c = 0; c < 6; c++)
    begin
      wr(`ADDR_OVERSAMPLING, 32'({c[2:0], c[2:0]}));
      forced(c[0] ? 32'h0000_0013 : 32'h0000_0023, 2);
      rd(`ADDR_TEMP_RESULT);
      chk(d, fx(t_val, c[2:0]), "temperature resolution");
      rd(`ADDR_PRESS_RESULT);
      chk(d, fx(p_val, c[2:0]), "pressure resolution");
    end
    $display("oversampling test done");
  endtask : t_osr
  task automatic t_filter;
    wr(`ADDR_FILTER_CONFIG, 32'h0000_0001);
    t_val <= 21'h10_0000;
    forced(32'h0000_0013, 2);
    rd(`ADDR_TEMP_RESULT);
    chk(d, fx(21'h10_0000, 3'd5), "seed passes");
    t_val <= 21'h00_0100;
    forced(32'h0000_0013, 2);
    rd(`ADDR_TEMP_RESULT);
    chk(d, fx(21'h08_0080, 3'd5), "filter average");
    p_val <= 21'h03_0303;
    forced(32'h0000_0011, 1);
    rd(`ADDR_PRESS_RESULT);
    chk(d, fx(21'h03_0303, 3'd5), "cleared on disable");
    rd(`ADDR_TEMP_RESULT);
    chk(d, fx(21'h08_0080, 3'd5), "skipped keeps result");
    t_val <= 21'h1e_0000;
    forced(32'h0000_0013, 2);
    rd(`ADDR_TEMP_RESULT);
    chk(d, fx(21'h1e_0000, 3'd5), "re-enable seeds");
    $display("filter test done");
  endtask : t_filter
  task automatic t_normal;
    int s;
    wr(`ADDR_FILTER_CONFIG, 32'h0000_0000);
    wr(`ADDR_RATE_SELECT, 32'h0000_0002);
    p_val <= 21'h01_2345;
    wr(`ADDR_MEASURE_CONTROL, 32'h0000_0033);
    wait_starts(6);
    chk(32'(gap), 32'h0000_0020, "sampling period");
    rd(`ADDR_PRESS_RESULT);
    chk(d, fx(21'h01_2345, 3'd5), "normal result");
    p_val <= 21'h1a_bcde;
    wait_starts(4);
    rd(`ADDR_PRESS_RESULT);
    chk(d, fx(21'h1a_bcde, 3'd5), "normal refresh");
    wr(`ADDR_MEASURE_CONTROL, 32'h0000_0013);
    rd(`ADDR_MEASURE_CONTROL);
    chk(32'(d[5:4]), 32'h0000_0003, "illegal change taken");
    while (conv_req !== 5'h15) @(posedge aclk);
    wr(`ADDR_MEASURE_CONTROL, 32'h0000_0003);
    rd(`ADDR_STATUS);
    chk(32'(d[2:1]), 32'h0000_0003, "change not held");
    forced(32'h0000_0003, 0);
    s = starts;
    repeat (60) @(posedge aclk);
    chk(32'(starts - s), 32'h0000_0000, "sleep converts");
    $display("normal test done");
  endtask : t_normal
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_osr();
    t_filter();
    t_normal();
    end_sim();
  end
endmodule : tb
